// >>> core/rpst_pkg.sv
// constants, register layout and types of the rail power sequencer slice
package rpst_pkg;
    localparam logic [7:0] RAIL4_SEL_ADDR = 8'h1C;
    localparam logic [7:0] DELAYS14_ADDR = 8'h1D;
    localparam logic [7:0] DELAYS_TRIG_ADDR = 8'h1E;
    localparam logic [7:0] RAIL4_SEL_RST = 8'h40;
    localparam logic [7:0] DELAYS14_RST = 8'h00;
    localparam logic [7:0] DELAYS_TRIG_RST = 8'h00;
    localparam logic [7:0] RDATA_RST = 8'h00;
    localparam logic [7:0] UNMAPPED_RDATA = 8'h00;

    localparam logic [3:0] SEL_NONE = 4'h0;
    localparam logic [3:0] SEL_FREE_A = 4'h8;
    localparam logic [3:0] SEL_FREE_B = 4'h9;
    localparam logic [3:0] SEL_WITH_SYS = 4'hF;
    localparam logic [3:0] STROBE_IDLE = 4'h0;
    localparam logic [3:0] STROBE_FIRST = 4'h1;
    localparam logic [3:0] STROBE_LAST = 4'h7;
    localparam logic [3:0] DELAY_FIRST = 4'h1;
    localparam logic [3:0] DELAY_LAST = 4'h6;
    localparam int NUM_DELAYS = 6;
    localparam int DELAY_FIELDS_W = 12;

    localparam logic [1:0] DLY_CODE_A = 2'h0;
    localparam logic [1:0] DLY_CODE_B = 2'h1;
    localparam logic [1:0] DLY_CODE_C = 2'h2;
    localparam int MCLK_HZ = 10_000_000;
    localparam int MS_PER_S = 1000;
    localparam int DLY_A_MS = 1;
    localparam int DLY_B_MS = 2;
    localparam int DLY_C_MS = 5;
    localparam int DLY_D_MS = 10;
    localparam int DLY_A_CYC = DLY_A_MS * (MCLK_HZ / MS_PER_S);
    localparam int DLY_B_CYC = DLY_B_MS * (MCLK_HZ / MS_PER_S);
    localparam int DLY_C_CYC = DLY_C_MS * (MCLK_HZ / MS_PER_S);
    localparam int DLY_D_CYC = DLY_D_MS * (MCLK_HZ / MS_PER_S);
    localparam int TIMER_W = 24;
    localparam logic [23:0] TIMER_ZERO = 24'h000000;
    localparam logic [23:0] TIMER_ONE = 24'h000001;

    typedef struct packed {
        logic [3:0] rail4_strobe_select;
        logic [3:0] spare;
    } rpst_sel_t;

    typedef struct packed {
        logic [1:0] fifth_delay_select;
        logic [1:0] sixth_delay_select;
        logic spare;
        logic power_up_trigger;
        logic power_down_trigger;
        logic instant_shutdown;
    } rpst_trig_t;

    typedef enum logic [1:0] {ST_IDLE, ST_UP, ST_DOWN} rpst_state_t;
endpackage : rpst_pkg

// >>> core/rpst_sequencer.sv
// sequencer slice: fourth rail strobe, six delays, power-up and power-down control
// Summary of operation
// - code zero leaves rail untouched by strobes
// - codes one to seven enable at that strobe
// - strobe select resets to strobe four
// - delay codes give 1, 2, 5, 10 ms
// - power-up trigger starts sequence, self-clears
// - power-down trigger starts shutdown, self-clears
// - normal shutdown runs power-up order reversed
// - instant shutdown drops controlled rails at once
// - shutdown on enable pin falling edge or trigger
// - shutdown leaves uncontrolled rails as they are
// - fifth, sixth delays and control bits reset zero
// - codes eight, nine free; fifteen with supply
`timescale 1ns/1ns
module rpst_sequencer #(
    parameter int DLY_A_CYCLES = rpst_pkg::DLY_A_CYC,
    parameter int DLY_B_CYCLES = rpst_pkg::DLY_B_CYC,
    parameter int DLY_C_CYCLES = rpst_pkg::DLY_C_CYC,
    parameter int DLY_D_CYCLES = rpst_pkg::DLY_D_CYC,
    parameter logic [7:0] DELAYS14_RESET = rpst_pkg::DELAYS14_RST
) (
    input wire logic mclk, // 10 MHz clock
    input wire logic rst, // synchronous reset, active high
    input wire logic [7:0] reg_addr, // register address
    input wire logic [7:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe, one cycle
    input wire logic reg_rd, // read strobe, one cycle
    output logic [7:0] reg_rdata, // read data, valid the cycle after reg_rd
    input wire logic power_enable_input, // falling edge (high to low) starts shutdown; a level that is already low does not
    output logic fourth_switch_rail, // enable of the fourth rail
    output logic seq_busy, // a sequence is running
    output logic [3:0] strobe_num // current strobe number
);
    import rpst_pkg::*;

    rpst_sel_t sel_reg, sel_next;
    logic [7:0] dl14_reg, dl14_next;
    rpst_trig_t trig_reg, trig_next;
    rpst_state_t state_reg, state_next;
    logic [3:0] strobe_reg, strobe_next;
    logic [TIMER_W-1:0] timer_reg, timer_next;
    logic rail_reg, rail_next;
    logic pen_reg, pen_next;
    logic busy_reg, busy_next;
    logic [7:0] rdata_reg, rdata_next;
    logic [DELAY_FIELDS_W-1:0] dly_fields;
    logic [TIMER_W-1:0] dly_cyc [1:NUM_DELAYS];
    logic [3:0] code;
    logic controlled;
    logic down_req;

    assign dly_fields = {dl14_reg, trig_reg.fifth_delay_select, trig_reg.sixth_delay_select};
    assign code = sel_reg.rail4_strobe_select;
    assign controlled = (code != SEL_NONE) && (code != SEL_FREE_A) && (code != SEL_FREE_B);
    assign down_req = trig_reg.power_down_trigger || (pen_reg && !power_enable_input);

    // one count per delay field
    for (genvar i = 1; i <= NUM_DELAYS; i++) begin : g_dly
        logic [1:0] fld;
        assign fld = dly_fields[DELAY_FIELDS_W - 2 * (i - 1) - 1 -: 2];
        always_comb begin
            if (fld == DLY_CODE_A) begin
                dly_cyc[i] = TIMER_W'(DLY_A_CYCLES);
            end else if (fld == DLY_CODE_B) begin
                dly_cyc[i] = TIMER_W'(DLY_B_CYCLES);
            end else if (fld == DLY_CODE_C) begin
                dly_cyc[i] = TIMER_W'(DLY_C_CYCLES);
            end else begin
                dly_cyc[i] = TIMER_W'(DLY_D_CYCLES);
            end
        end
    end

    function automatic logic [TIMER_W-1:0] load_of(input logic [3:0] idx);
        logic [TIMER_W-1:0] r;
        r = TIMER_ZERO;
        if (idx >= DELAY_FIRST && idx <= DELAY_LAST) begin
            r = dly_cyc[idx];
        end
        return r;
    endfunction : load_of

    always_comb begin
        sel_next = sel_reg;
        dl14_next = dl14_reg;
        trig_next = trig_reg;
        state_next = state_reg;
        strobe_next = strobe_reg;
        timer_next = timer_reg;
        rail_next = rail_reg;
        pen_next = power_enable_input;
        rdata_next = rdata_reg;
        trig_next.power_up_trigger = 1'b0;
        trig_next.power_down_trigger = 1'b0;
        if (down_req) begin
            if (trig_reg.instant_shutdown) begin
                if (controlled) begin
                    rail_next = 1'b0;
                end
                state_next = ST_IDLE;
                strobe_next = STROBE_IDLE;
                timer_next = TIMER_ZERO;
            end else begin
                state_next = ST_DOWN;
                strobe_next = STROBE_LAST;
                timer_next = load_of(STROBE_LAST - DELAY_FIRST);
            end
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (trig_reg.power_up_trigger) begin
                        state_next = ST_UP;
                        strobe_next = STROBE_FIRST;
                        timer_next = load_of(STROBE_FIRST);
                        if (code == SEL_WITH_SYS) begin
                            rail_next = 1'b1;
                        end
                    end
                end
                ST_UP: begin
                    if (code == strobe_reg) begin
                        rail_next = 1'b1;
                    end
                    if (timer_reg != TIMER_ZERO) begin
                        timer_next = timer_reg - TIMER_ONE;
                    end else if (strobe_reg == STROBE_LAST) begin
                        state_next = ST_IDLE;
                        strobe_next = STROBE_IDLE;
                    end else begin
                        strobe_next = strobe_reg + STROBE_FIRST;
                        timer_next = load_of(strobe_reg + STROBE_FIRST);
                    end
                end
                ST_DOWN: begin
                    if (code == strobe_reg) begin
                        rail_next = 1'b0;
                    end
                    if (timer_reg != TIMER_ZERO) begin
                        timer_next = timer_reg - TIMER_ONE;
                    end else if (strobe_reg == STROBE_FIRST) begin
                        state_next = ST_IDLE;
                        strobe_next = STROBE_IDLE;
                        // a rail that came up with the supply came up first, so it drops last
                        if (code == SEL_WITH_SYS) begin
                            rail_next = 1'b0;
                        end
                    end else begin
                        strobe_next = strobe_reg - STROBE_FIRST;
                        timer_next = load_of(strobe_reg - STROBE_FIRST - DELAY_FIRST);
                    end
                end
                default: begin
                    state_next = ST_IDLE;
                end
            endcase
        end
        // a host write lands after the consume, so a trigger written in the consume cycle is kept
        if (reg_wr) begin
            if (reg_addr == RAIL4_SEL_ADDR) begin
                sel_next = rpst_sel_t'(reg_wdata);
            end else if (reg_addr == DELAYS14_ADDR) begin
                dl14_next = reg_wdata;
            end else if (reg_addr == DELAYS_TRIG_ADDR) begin
                trig_next = rpst_trig_t'(reg_wdata);
            end
        end
        if (reg_rd) begin
            if (reg_addr == RAIL4_SEL_ADDR) begin
                rdata_next = sel_reg;
            end else if (reg_addr == DELAYS14_ADDR) begin
                rdata_next = dl14_reg;
            end else if (reg_addr == DELAYS_TRIG_ADDR) begin
                rdata_next = trig_reg;
            end else begin
                rdata_next = UNMAPPED_RDATA;
            end
        end
        busy_next = (state_next != ST_IDLE);
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            sel_reg <= rpst_sel_t'(RAIL4_SEL_RST);
            dl14_reg <= DELAYS14_RESET;
            trig_reg <= rpst_trig_t'(DELAYS_TRIG_RST);
            state_reg <= ST_IDLE;
            strobe_reg <= STROBE_IDLE;
            timer_reg <= TIMER_ZERO;
            rail_reg <= 1'b0;
            pen_reg <= 1'b0;
            busy_reg <= 1'b0;
            rdata_reg <= RDATA_RST;
        end else begin
            sel_reg <= sel_next;
            dl14_reg <= dl14_next;
            trig_reg <= trig_next;
            state_reg <= state_next;
            strobe_reg <= strobe_next;
            timer_reg <= timer_next;
            rail_reg <= rail_next;
            pen_reg <= pen_next;
            busy_reg <= busy_next;
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign fourth_switch_rail = rail_reg;
    assign seq_busy = busy_reg;
    assign strobe_num = strobe_reg;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence up_write_s;
        reg_wr && reg_addr == DELAYS_TRIG_ADDR && reg_wdata[2];
    endsequence
    sequence down_write_s;
        reg_wr && reg_addr == DELAYS_TRIG_ADDR && reg_wdata[1];
    endsequence

    free_rail_hold_a: assert property (!controlled && !reg_wr |=> $stable(rail_reg))
        else $error("uncontrolled rail changed");
    strobe_enable_a: assert property (state_reg == ST_UP && code == strobe_reg && !down_req
        |=> rail_reg)
        else $error("rail not enabled at its strobe");
    reset_values_a: assert property (disable iff (1'b0) $past(rst) |-> sel_reg == RAIL4_SEL_RST
        && trig_reg == DELAYS_TRIG_RST)
        else $error("wrong reset value");
    up_selfclear_a: assert property (up_write_s ##1 (!down_req && !reg_wr && state_reg == ST_IDLE)
        |=> !trig_reg.power_up_trigger && state_reg != ST_IDLE)
        else $error("power-up trigger did not self-clear or start");
    down_selfclear_a: assert property (down_write_s ##1 !reg_wr
        |=> !trig_reg.power_down_trigger)
        else $error("power-down trigger did not self-clear");
    down_order_a: assert property (state_reg == ST_DOWN && $past(state_reg) == ST_DOWN
        && !$past(down_req) |-> strobe_reg <= $past(strobe_reg))
        else $error("shutdown strobes not descending");
    instant_off_a: assert property (down_req && trig_reg.instant_shutdown && controlled
        |=> !rail_reg && state_reg == ST_IDLE)
        else $error("instant shutdown did not drop rail");
    pin_shutdown_a: assert property ($fell(power_enable_input) && !trig_reg.instant_shutdown
        |=> state_reg == ST_DOWN && strobe_reg == STROBE_LAST)
        else $error("enable pin low did not start shutdown");
    delay_load_a: assert property (state_reg == ST_UP && timer_reg == TIMER_ZERO && !down_req
        && strobe_reg < STROBE_LAST |=> timer_reg == load_of(strobe_reg))
        else $error("wrong delay loaded between strobes");
endmodule : rpst_sequencer

// >>> dv/rpst_host.sv
// host model driving the sequencer register port
`timescale 1ns/1ns
module rpst_host (
    input wire logic mclk, // clock
    output logic [7:0] reg_addr, // address
    output logic [7:0] reg_wdata, // write data
    output logic reg_wr, // write strobe
    output logic reg_rd, // read strobe
    input wire logic [7:0] reg_rdata // read data
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // unlock is taken as done before every write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(posedge mclk);
        #1 d = reg_rdata;
    endtask : rd
endmodule : rpst_host

// >>> dv/tb.sv
// testbench of the rail power sequencer slice
`timescale 1ns/1ns
module tb;
    import rpst_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic pin = 1'b1;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_v;
    logic reg_wr, reg_rd, rail, busy;
    logic [3:0] strobe_num;
    logic [1:0] dc [1:6];
    int n_errors = 0;
    int comparisons = 0;
    always #50 mclk = ~mclk;
    rpst_host host (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    rpst_sequencer #(.DLY_A_CYCLES(3), .DLY_B_CYCLES(5), .DLY_C_CYCLES(7),
        .DLY_D_CYCLES(9)) DUT (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .power_enable_input(pin), .fourth_switch_rail(rail), .seq_busy(busy),
        .strobe_num(strobe_num));
    function automatic int cyc(input logic [1:0] c);
        return 3 + 2 * int'(c);
    endfunction : cyc
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic close_out();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out
    task automatic trig(input logic u, input logic d, input logic i);
        host.wr(DELAYS_TRIG_ADDR, {dc[5], dc[6], 1'b0, u, d, i});
    endtask : trig
    // expected strobe walk built from the delay codes, compared each cycle
    task automatic walk(input logic up, input logic [3:0] code, input logic r0);
        int q[$];
        logic r;
        r = r0;
        for (int k = 1; k <= 7; k++) begin
            if (up) begin
                repeat ((k == 7) ? 1 : cyc(dc[k]) + 1) q.push_back(k);
            end else begin
                repeat ((k == 7) ? 1 : cyc(dc[7 - k]) + 1) q.push_back(8 - k);
            end
        end
        repeat (8) if (strobe_num === 4'h0) begin
            @(posedge mclk);
            #1;
        end
        foreach (q[i]) begin
            chk("strobe", 8'(q[i]), {4'h0, strobe_num});
            chk("rail", {7'h00, r}, {7'h00, rail});
            chk("busy", 8'h01, {7'h00, busy});
            if (q[i] == code && code >= 1 && code <= 7) r = up;
            if (!up && q[i] == 1 && code == SEL_WITH_SYS) r = 1'b0;
            @(posedge mclk);
            #1;
        end
        chk("strobe end", 8'h00, {4'h0, strobe_num});
        chk("rail end", {7'h00, r}, {7'h00, rail});
    endtask : walk
    initial begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        close_out();
    end
    initial begin
        void'($urandom(32'hE3694787));
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        host.rd(RAIL4_SEL_ADDR, rd_v);
        chk("sel reset", RAIL4_SEL_RST, rd_v);
        chk("rail reset", 8'h00, {7'h00, rail});
        chk("busy reset", 8'h00, {7'h00, busy});
        chk("strobe reset", 8'h00, {4'h0, strobe_num});
        host.rd(DELAYS14_ADDR, rd_v);
        chk("delays reset", DELAYS14_RST, rd_v);
        host.rd(DELAYS_TRIG_ADDR, rd_v);
        chk("trig reset", 8'h00, rd_v);
        host.rd(8'h1F, rd_v);
        chk("unmapped", 8'h00, rd_v);
        for (int c = 0; c <= 9; c++) begin
            for (int k = 1; k <= 6; k++) dc[k] = 2'($urandom_range(3));
            host.wr(DELAYS14_ADDR, {dc[1], dc[2], dc[3], dc[4]});
            host.rd(DELAYS14_ADDR, rd_v);
            chk("delays", {dc[1], dc[2], dc[3], dc[4]}, rd_v);
            host.wr(RAIL4_SEL_ADDR, {4'(c), 4'h0});
            trig(1'b1, 1'b0, 1'b0);
            walk(1'b1, 4'(c), 1'b0);
            host.rd(DELAYS_TRIG_ADDR, rd_v);
            chk("up clear", {dc[5], dc[6], 4'h0}, rd_v);
            trig(1'b0, 1'b1, 1'b0);
            walk(1'b0, 4'(c), c >= 1 && c <= 7);
            host.rd(DELAYS_TRIG_ADDR, rd_v);
            chk("down clear", {dc[5], dc[6], 4'h0}, rd_v);
        end
        host.wr(RAIL4_SEL_ADDR, {SEL_WITH_SYS, 4'h0});
        trig(1'b1, 1'b0, 1'b0);
        walk(1'b1, SEL_WITH_SYS, 1'b1);
        trig(1'b0, 1'b1, 1'b0);
        walk(1'b0, SEL_WITH_SYS, 1'b1);
        host.wr(RAIL4_SEL_ADDR, 8'h20);
        trig(1'b1, 1'b0, 1'b0);
        walk(1'b1, 4'h2, 1'b0);
        host.wr(RAIL4_SEL_ADDR, 8'h00);
        trig(1'b0, 1'b1, 1'b0);
        walk(1'b0, 4'h0, 1'b1);
        host.wr(RAIL4_SEL_ADDR, 8'h20);
        @(posedge mclk);
        pin <= 1'b0;
        walk(1'b0, 4'h2, 1'b1);
        @(posedge mclk);
        pin <= 1'b1;
        host.wr(RAIL4_SEL_ADDR, 8'h50);
        trig(1'b1, 1'b0, 1'b0);
        walk(1'b1, 4'h5, 1'b0);
        trig(1'b0, 1'b0, 1'b1);
        @(posedge mclk);
        pin <= 1'b0;
        repeat (3) @(posedge mclk);
        #1;
        chk("instant rail", 8'h00, {7'h00, rail});
        chk("instant busy", 8'h00, {7'h00, busy});
        chk("instant strobe", 8'h00, {4'h0, strobe_num});
        // reset in the middle of a power-up with the rail already on
        @(posedge mclk);
        pin <= 1'b1;
        host.wr(RAIL4_SEL_ADDR, 8'h10);
        trig(1'b1, 1'b0, 1'b0);
        repeat (2) @(posedge mclk);
        rst <= 1'b1;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        host.rd(RAIL4_SEL_ADDR, rd_v);
        chk("sel rerun", RAIL4_SEL_RST, rd_v);
        host.rd(DELAYS_TRIG_ADDR, rd_v);
        chk("trig rerun", DELAYS_TRIG_RST, rd_v);
        chk("rail rerun", 8'h00, {7'h00, rail});
        chk("busy rerun", 8'h00, {7'h00, busy});
        chk("strobe rerun", 8'h00, {4'h0, strobe_num});
        close_out();
    end
endmodule : tb
